// >>> logic/sdwb_ctl.sv
// Write-burst controller end: APB registers, write FIFO and command sequencer
`timescale 1ns/100ps
`default_nettype none
module sdwb_ctl import sdwb_pkg::*; (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic [FIFO_W-1:0] wdata_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  sdwb_if.ctl                    link
);
  typedef enum logic [3:0] {
    C_IDLE, C_RST, C_LOAD, C_ACT, C_WR, C_LAT, C_PRE, C_DATA, C_REC, C_PRECH
  } sdwb_cst_t;

  sdwb_cst_t         st_r, st_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [31:0]       tim0_r, tim0_nxt, tim1_r, tim1_nxt, tim2_r, tim2_nxt;
  logic [31:0]       prdata_r, prdata_nxt, buf0_r, buf0_nxt, buf1_r, buf1_nxt;
  logic [7:0]        cnt_r, cnt_nxt, actp_r, actp_nxt;
  logic [3:0]        ccd_r, ccd_nxt, ccd_eff;
  logic [1:0]        bank_r, bank_nxt, beat_r, beat_nxt, cbank_r, cbank_nxt;
  logic              cchop_r, cchop_nxt, crd_r, crd_nxt, clong_r, clong_nxt;
  logic              chop_r, chop_nxt, rd_r, rd_nxt, long_r, long_nxt, wsel_r, wsel_nxt;
  logic              go_r, go_nxt, mrs_r, mrs_nxt, rin_r, rin_nxt;
  logic              cfgerr_r, cfgerr_nxt, done_r, done_nxt;
  logic              go_take, mrs_take, rin_take, mrs_set, cfg_set, done_set;
  logic              wr_en, hit, cfg_bad, crcdm, f_valid, f_ready;
  logic [FIFO_W-1:0] f_data;
  sdwb_cmd_t         cmd_r, cmd_nxt;
  logic [15:0]       dq_r, dq_nxt;
  logic              dqs_r, dqs_nxt, drst_r, drst_nxt;
  logic [7:0]        rec_lim, turn_lim;
  logic [63:0]       wide;

  // Variant picker shared by recovery and turnaround
  function automatic logic [7:0] pick(input logic crc, input logic data_bus_inversion, input logic [7:0] v,
                                      input logic [7:0] v_dbi, input logic [7:0] v_crc);
    return crc ? v_crc : (data_bus_inversion ? v_dbi : v);
  endfunction

  sdwb_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (wvalid_i),
    .in_data_i   (wdata_i),
    .in_ready_o  (wready_o),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (f_ready)
  );

  // Zero wait states keep the bus side trivial
  assign pready_o     = 1'b1;
  assign prdata_o     = prdata_r;
  assign pslverr_o    = psel_i && penable_i && !hit;
  assign f_ready      = (st_r == C_LOAD);
  assign link.cmd     = cmd_r;
  assign link.bank    = bank_r;
  assign link.chop    = chop_r;
  assign link.mode    = mode_r;
  assign link.dq      = dq_r;
  assign link.dmi_n   = DMI_IDLE;
  assign link.dqs     = dqs_r;
  assign link.dev_rst = drst_r;

  always_comb begin
    wr_en   = psel_i && penable_i && pwrite_i;
    hit     = (paddr_i == A_CTRL) || (paddr_i == A_MODE) || (paddr_i == A_TIM0) ||
              (paddr_i == A_TIM1) || (paddr_i == A_TIM2) || (paddr_i == A_STAT);
    crcdm   = mode_r[CRC_BIT] && mode_r[MASK_BIT];
    rec_lim = pick(crcdm, mode_r[INV_BIT], tim0_r[7:0], tim0_r[15:8], tim0_r[23:16]);
    turn_lim = pick(crcdm, 1'b0, long_r ? tim1_r[15:8] : tim1_r[7:0], 8'h00,
                    long_r ? tim1_r[31:24] : tim1_r[23:16]);
    // Refuse latency settings that two-cycle preamble cannot meet
    cfg_bad = mode_r[PRE2_BIT] && ((mode_r[CLAT_LSB+:5] < {1'b0, tim2_r[7:4]} + 5'h01) ||
              (mode_r[CLAT_LSB+:5] == CLAT_FORBID));
    ccd_eff = (mode_r[PRE2_BIT] && tim2_r[3:0] == CCD_FORBID) ?
              tim2_r[3:0] + 4'h1 : tim2_r[3:0];
    wide    = {buf1_r, buf0_r};
  end

  // Register file
  always_comb begin
    mode_nxt   = mode_r;
    tim0_nxt   = tim0_r;
    tim1_nxt   = tim1_r;
    tim2_nxt   = tim2_r;
    cchop_nxt  = cchop_r;
    cbank_nxt  = cbank_r;
    crd_nxt    = crd_r;
    clong_nxt  = clong_r;
    prdata_nxt = prdata_r;
    // Set wins over clear on every pending and sticky bit
    go_nxt     = go_r && !go_take;
    mrs_nxt    = (mrs_r && !mrs_take) || mrs_set;
    rin_nxt    = rin_r && !rin_take;
    cfgerr_nxt = cfgerr_r;
    done_nxt   = done_r;
    if (wr_en && paddr_i == A_CTRL) begin
      cchop_nxt = pwdata_i[C_CHOP];
      cbank_nxt = pwdata_i[C_BANK+:2];
      crd_nxt   = pwdata_i[C_RD];
      clong_nxt = pwdata_i[C_LONG];
      go_nxt    = go_nxt || pwdata_i[C_GO];
      mrs_nxt   = mrs_nxt || pwdata_i[C_MRS];
      rin_nxt   = rin_nxt || pwdata_i[C_REINIT];
    end
    if (wr_en && paddr_i == A_MODE) mode_nxt = pwdata_i[MODE_W-1:0];
    if (wr_en && paddr_i == A_TIM0) tim0_nxt = pwdata_i;
    if (wr_en && paddr_i == A_TIM1) tim1_nxt = pwdata_i;
    if (wr_en && paddr_i == A_TIM2) tim2_nxt = {24'h000000, pwdata_i[7:0]};
    if (wr_en && paddr_i == A_STAT) begin
      cfgerr_nxt = cfgerr_r && !pwdata_i[S_CFGERR];
      done_nxt   = done_r && !pwdata_i[S_DONE];
    end
    cfgerr_nxt = cfgerr_nxt || cfg_set;
    done_nxt   = done_nxt || done_set;
    if (psel_i && !penable_i) begin
      case (paddr_i)
        A_CTRL:  prdata_nxt = {24'h000000, clong_r, crd_r, rin_r, mrs_r, cbank_r, cchop_r, go_r};
        A_MODE:  prdata_nxt = {18'h00000, mode_r};
        A_TIM0:  prdata_nxt = tim0_r;
        A_TIM1:  prdata_nxt = tim1_r;
        A_TIM2:  prdata_nxt = tim2_r;
        A_STAT:  prdata_nxt = {29'h00000000, done_r, cfgerr_r, st_r != C_IDLE};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Command sequencer; strobe, data and device reset follow the next state so they line up with it
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    beat_nxt = beat_r;
    wsel_nxt = wsel_r;
    buf0_nxt = buf0_r;
    buf1_nxt = buf1_r;
    bank_nxt = bank_r;
    chop_nxt = chop_r;
    rd_nxt   = rd_r;
    long_nxt = long_r;
    cmd_nxt  = SDWB_NOP;
    actp_nxt = (actp_r == 8'hFF) ? actp_r : actp_r + 8'h01;
    ccd_nxt  = (ccd_r == 4'hF) ? ccd_r : ccd_r + 4'h1;
    go_take  = 1'b0;
    mrs_take = 1'b0;
    rin_take = 1'b0;
    mrs_set  = 1'b0;
    cfg_set  = 1'b0;
    done_set = 1'b0;
    case (st_r)
      C_IDLE: begin
        if (rin_r) begin
          rin_take = 1'b1;
          cnt_nxt  = 8'(RST_CYC - 1);
          st_nxt   = C_RST;
        end else if (mrs_r) begin
          mrs_take = 1'b1;
          cmd_nxt  = SDWB_MRS;
        end else if (go_r) begin
          go_take = 1'b1;
          if (cfg_bad) begin
            cfg_set = 1'b1;
          end else begin
            chop_nxt = cchop_r;
            bank_nxt = cbank_r;
            rd_nxt   = crd_r;
            long_nxt = clong_r;
            wsel_nxt = 1'b0;
            st_nxt   = C_LOAD;
          end
        end
      end
      C_RST: begin
        if (cnt_r == 8'h00) begin
          mrs_set = 1'b1;
          st_nxt  = C_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      C_LOAD: begin
        // Whole burst is gathered first so the link never runs dry mid-burst
        if (f_valid) begin
          if (wsel_r) buf1_nxt = f_data;
          else buf0_nxt = f_data;
          wsel_nxt = 1'b1;
          if (wsel_r || sdwb_chop(mode_r[BM_LSB+:2], chop_r)) begin
            cmd_nxt  = SDWB_ACT;
            actp_nxt = 8'h00;
            st_nxt   = C_ACT;
          end
        end
      end
      C_ACT: st_nxt = C_WR;
      C_WR: begin
        // Widened so the saturated count does not wrap to zero
        if ({1'b0, ccd_r} + 5'h01 >= {1'b0, ccd_eff}) begin
          cmd_nxt = SDWB_WR;
          ccd_nxt = 4'h0;
          cnt_nxt = {2'h0, sdwb_wlat(mode_r)} - {6'h00, sdwb_pre(mode_r)} - 8'h01;
          st_nxt  = C_LAT;
        end
      end
      C_LAT: begin
        if (cnt_r == 8'h00) begin
          cnt_nxt = {6'h00, sdwb_pre(mode_r)} - 8'h01;
          st_nxt  = C_PRE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      C_PRE: begin
        if (cnt_r == 8'h00) begin
          beat_nxt = 2'h0;
          st_nxt   = C_DATA;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      C_DATA: begin
        if ({1'b0, beat_r} == sdwb_nclk(sdwb_chop(mode_r[BM_LSB+:2], chop_r)) - 3'h1) begin
          cnt_nxt = 8'h00;
          st_nxt  = C_REC;
        end else begin
          beat_nxt = beat_r + 2'h1;
        end
      end
      C_REC: begin
        // Count starts at the first edge after the last beat
        cnt_nxt = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
        if (rd_r && ({1'b0, cnt_r} + 9'h001 >= {1'b0, turn_lim})) begin
          cmd_nxt = SDWB_RD;
          rd_nxt  = 1'b0;
        end else if (!rd_r && ({1'b0, cnt_r} + 9'h001 >= {1'b0, rec_lim}) &&
                     ({1'b0, actp_r} + 9'h001 >= {1'b0, tim0_r[31:24]})) begin
          cmd_nxt = SDWB_PRE;
          st_nxt  = C_PRECH;
        end
      end
      C_PRECH: begin
        done_set = 1'b1;
        st_nxt   = C_IDLE;
      end
      default: st_nxt = C_IDLE;
    endcase
    dqs_nxt  = (st_nxt == C_PRE) || (st_nxt == C_DATA);
    dq_nxt   = (st_nxt == C_DATA) ? wide[{beat_nxt, 4'h0}+:16] : 16'h0000;
    drst_nxt = (st_nxt == C_RST);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r     <= C_IDLE;
      mode_r   <= MODE_RST;
      tim0_r   <= TIM0_RST;
      tim1_r   <= TIM1_RST;
      tim2_r   <= TIM2_RST;
      prdata_r <= 32'h00000000;
      buf0_r   <= 32'h00000000;
      buf1_r   <= 32'h00000000;
      cnt_r    <= 8'h00;
      actp_r   <= 8'h00;
      ccd_r    <= 4'hF;
      bank_r   <= 2'h0;
      beat_r   <= 2'h0;
      cbank_r  <= 2'h0;
      {cchop_r, crd_r, clong_r, chop_r, rd_r, long_r, wsel_r} <= 7'h00;
      {go_r, mrs_r, rin_r, cfgerr_r, done_r} <= 5'h00;
      cmd_r    <= SDWB_NOP;
      dq_r     <= 16'h0000;
      dqs_r    <= 1'b0;
      drst_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      mode_r   <= mode_nxt;
      tim0_r   <= tim0_nxt;
      tim1_r   <= tim1_nxt;
      tim2_r   <= tim2_nxt;
      prdata_r <= prdata_nxt;
      buf0_r   <= buf0_nxt;
      buf1_r   <= buf1_nxt;
      cnt_r    <= cnt_nxt;
      actp_r   <= actp_nxt;
      ccd_r    <= ccd_nxt;
      bank_r   <= bank_nxt;
      beat_r   <= beat_nxt;
      cbank_r  <= cbank_nxt;
      {cchop_r, crd_r, clong_r, chop_r, rd_r, long_r, wsel_r} <=
        {cchop_nxt, crd_nxt, clong_nxt, chop_nxt, rd_nxt, long_nxt, wsel_nxt};
      {go_r, mrs_r, rin_r, cfgerr_r, done_r} <= {go_nxt, mrs_nxt, rin_nxt, cfgerr_nxt, done_nxt};
      cmd_r    <= cmd_nxt;
      dq_r     <= dq_nxt;
      dqs_r    <= dqs_nxt;
      drst_r   <= drst_nxt;
    end
  end
endmodule // sdwb_ctl
`default_nettype wire

// >>> common/sdwb_pkg.sv
// Constants, types and helpers shared by both ends of the write-burst link
package sdwb_pkg;
  localparam int CLK_NS      = 100;
  localparam int RST_HOLD_NS = 500;
  localparam int RST_CYC     = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_W      = 32;
  localparam int FIFO_D      = 4;

  // Mode word carried on the link during a mode register load
  localparam int MODE_W   = 14;
  localparam int BM_LSB   = 0;
  localparam int CLAT_LSB = 2;
  localparam int ADDL_LSB = 7;
  localparam int PRE2_BIT = 10;
  localparam int INV_BIT  = 11;
  localparam int CRC_BIT  = 12;
  localparam int MASK_BIT = 13;
  localparam logic [MODE_W-1:0] MODE_RST = 14'h0024;

  localparam logic [1:0] BM_EIGHT = 2'h0;
  localparam logic [1:0] BM_SEL   = 2'h1;
  localparam logic [1:0] BM_CHOP  = 2'h2;
  localparam logic [2:0] N_EIGHT  = 3'h4;
  localparam logic [2:0] N_CHOP   = 3'h2;
  localparam logic [3:0] CCD_FORBID  = 4'h6;
  localparam logic [4:0] CLAT_FORBID = 5'h09;
  localparam logic [1:0] DMI_IDLE   = 2'h3;

  // Register map of the controller
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_TIM0 = 8'h08;
  localparam logic [7:0] A_TIM1 = 8'h0C;
  localparam logic [7:0] A_TIM2 = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam int C_GO = 0;
  localparam int C_CHOP = 1;
  localparam int C_BANK = 2;
  localparam int C_MRS = 4;
  localparam int C_REINIT = 5;
  localparam int C_RD = 6;
  localparam int C_LONG = 7;
  localparam int S_BUSY = 0;
  localparam int S_CFGERR = 1;
  localparam int S_DONE = 2;
  localparam logic [31:0] TIM0_RST = 32'h140E0D0C;
  localparam logic [31:0] TIM1_RST = 32'h07030602;
  localparam logic [31:0] TIM2_RST = 32'h00000094;

  typedef enum logic [2:0] {SDWB_NOP, SDWB_MRS, SDWB_ACT, SDWB_WR, SDWB_RD, SDWB_PRE} sdwb_cmd_t;

  function automatic logic sdwb_chop(input logic [1:0] bm, input logic sel);
    return (bm == BM_CHOP) || ((bm == BM_SEL) && !sel);
  endfunction

  function automatic logic [2:0] sdwb_nclk(input logic chop);
    return chop ? N_CHOP : N_EIGHT;
  endfunction

  function automatic logic [5:0] sdwb_wlat(input logic [MODE_W-1:0] m);
    return {3'h0, m[ADDL_LSB+:3]} + {1'b0, m[CLAT_LSB+:5]};
  endfunction

  function automatic logic [1:0] sdwb_pre(input logic [MODE_W-1:0] m);
    return m[PRE2_BIT] ? 2'h2 : 2'h1;
  endfunction
endpackage

// >>> common/sdwb_if.sv
// Link between the write-burst controller and the memory device
`timescale 1ns/100ps
`default_nettype none
interface sdwb_if;
  sdwb_pkg::sdwb_cmd_t             cmd;
  logic [1:0]                      bank;
  logic                            chop;
  logic [sdwb_pkg::MODE_W-1:0]     mode;
  logic [15:0]                     dq;
  logic [1:0]                      dmi_n;
  logic                            dqs;
  logic                            dev_rst;
  modport ctl (output cmd, bank, chop, mode, dq, dmi_n, dqs, dev_rst);
  modport dev (input cmd, bank, chop, mode, dq, dmi_n, dqs, dev_rst);
endinterface
`default_nettype wire

// >>> logic/sdwb_fifo.sv
// Write data FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sdwb_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready_o  = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rp_r];

  // Depth must be a power of two so the pointers wrap by themselves
  always_comb begin
    push    = in_valid_i && in_ready_o;
    pop     = out_valid_o && out_ready_i;
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
endmodule // sdwb_fifo
`default_nettype wire

// >>> logic/sdwb_dev.sv
// Memory device end: burst length decode and write data capture
`timescale 1ns/100ps
`default_nettype none
module sdwb_dev import sdwb_pkg::*; (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  sdwb_if.dev              link,
  input  wire logic [3:0]  rd_addr_i,
  output logic [15:0]      rd_data_o,
  output logic             beat_vld_o,
  output logic [15:0]      beat_data_o,
  output logic             chop_o,
  output logic             wr_err_o
);
  typedef enum logic [1:0] {D_IDLE, D_LAT, D_PRE, D_DATA} sdwb_dst_t;
  sdwb_dst_t         st_r, st_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [5:0]        cnt_r, cnt_nxt;
  logic              chop_r, chop_nxt, err_r, err_nxt, vld_r, vld_nxt;
  logic [1:0]        bank_r, bank_nxt, beat_r, beat_nxt, wen;
  logic [15:0]       bdat_r, bdat_nxt, rd_r, rd_nxt;
  logic [15:0]       mem [0:15];

  assign rd_data_o   = rd_r;
  assign beat_vld_o  = vld_r;
  assign beat_data_o = bdat_r;
  assign chop_o      = chop_r;
  assign wr_err_o    = err_r;

  always_comb begin
    st_nxt   = st_r;
    mode_nxt = mode_r;
    cnt_nxt  = cnt_r;
    chop_nxt = chop_r;
    bank_nxt = bank_r;
    beat_nxt = beat_r;
    bdat_nxt = bdat_r;
    err_nxt  = 1'b0;
    vld_nxt  = 1'b0;
    wen      = 2'h0;
    rd_nxt   = mem[rd_addr_i];
    case (st_r)
      D_IDLE: begin
        if (link.cmd == SDWB_MRS) begin
          mode_nxt = link.mode;
        end else if (link.cmd == SDWB_WR) begin
          // Chop select bit only matters in on-the-fly mode
          chop_nxt = sdwb_chop(mode_r[BM_LSB+:2], link.chop);
          bank_nxt = link.bank;
          beat_nxt = 2'h0;
          cnt_nxt  = sdwb_wlat(mode_r) - {4'h0, sdwb_pre(mode_r)} - 6'h2;
          st_nxt   = D_LAT;
        end
      end
      D_LAT: begin
        if (cnt_r == 6'h0) begin
          st_nxt  = D_PRE;
          cnt_nxt = {4'h0, sdwb_pre(mode_r)} - 6'h1;
        end else begin
          cnt_nxt = cnt_r - 6'h1;
        end
      end
      D_PRE: begin
        if (!link.dqs) begin
          err_nxt = 1'b1;
          st_nxt  = D_IDLE;
        end else if (cnt_r == 6'h0) begin
          st_nxt = D_DATA;
        end else begin
          cnt_nxt = cnt_r - 6'h1;
        end
      end
      D_DATA: begin
        // Lost strobe spoils only this burst; the beats so far stay written
        if (!link.dqs) begin
          err_nxt = 1'b1;
          st_nxt  = D_IDLE;
        end else begin
          vld_nxt  = 1'b1;
          wen      = (mode_r[MASK_BIT] && !mode_r[INV_BIT]) ? link.dmi_n : 2'h3;
          bdat_nxt = mode_r[INV_BIT] ?
                     link.dq ^ {{8{~link.dmi_n[1]}}, {8{~link.dmi_n[0]}}} : link.dq;
          beat_nxt = beat_r + 2'h1;
          if ({1'b0, beat_r} == sdwb_nclk(chop_r) - 3'h1) begin
            st_nxt = D_IDLE;
          end
        end
      end
      default: st_nxt = D_IDLE;
    endcase
    if (link.dev_rst) begin
      st_nxt   = D_IDLE;
      mode_nxt = MODE_RST;
      wen      = 2'h0;
      err_nxt  = 1'b0;
      vld_nxt  = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r   <= D_IDLE;
      mode_r <= MODE_RST;
      cnt_r  <= 6'h0;
      chop_r <= 1'b0;
      bank_r <= 2'h0;
      beat_r <= 2'h0;
      bdat_r <= 16'h0000;
      err_r  <= 1'b0;
      vld_r  <= 1'b0;
      rd_r   <= 16'h0000;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      cnt_r  <= cnt_nxt;
      chop_r <= chop_nxt;
      bank_r <= bank_nxt;
      beat_r <= beat_nxt;
      bdat_r <= bdat_nxt;
      err_r  <= err_nxt;
      vld_r  <= vld_nxt;
      rd_r   <= rd_nxt;
    end
    if (wen[0]) begin
      mem[{bank_r, beat_r}][7:0] <= bdat_nxt[7:0];
    end
    if (wen[1]) begin
      mem[{bank_r, beat_r}][15:8] <= bdat_nxt[15:8];
    end
  end
endmodule // sdwb_dev
`default_nettype wire

// >>> tb/sdwb_props.sv
// Link assertions for the write-burst pair
`timescale 1ns/100ps
`default_nettype none
module sdwb_props import sdwb_pkg::*; (
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire sdwb_cmd_t         cmd,
  input wire logic              chop,
  input wire logic [MODE_W-1:0] mode,
  input wire logic              dqs,
  input wire logic              dev_rst
);
  logic [MODE_W-1:0] mode_r;
  logic [7:0]        age_r;
  logic [7:0]        run_r;
  logic              chop_r;
  wire  [1:0]        bm = mode_r[1:0];
  wire  [7:0]        pl = {6'h00, sdwb_pre(mode_r)};
  wire  [7:0]        wlat = {2'h0, sdwb_wlat(mode_r)};
  wire  [7:0]        nb = (bm == BM_CHOP || (bm == BM_SEL && !chop_r)) ? 8'h02 : 8'h04;
  // Age saturates so an old write never aliases a new one
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || dev_rst) begin
      mode_r <= MODE_RST;
      age_r <= 8'hFF;
      run_r <= 8'h00;
      chop_r <= 1'b0;
    end else begin
      if (cmd == SDWB_MRS) begin
        mode_r <= mode;
      end
      if (cmd == SDWB_WR) begin
        age_r <= 8'h00;
        chop_r <= chop;
      end else if (age_r != 8'hFF) begin
        age_r <= age_r + 8'h01;
      end
      run_r <= dqs ? run_r + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rst_hold;
    (cmd == SDWB_NOP && dev_rst) [*5];
  endsequence
  sequence s_reload;
    !dev_rst ##[1:40] cmd == SDWB_MRS;
  endsequence
  a_fixed_chop: assert property ($fell(dqs) && bm == BM_CHOP |-> run_r == pl + 8'h02)
    else $error("fixed chop length wrong");
  a_sel_chop: assert property ($fell(dqs) && bm == BM_SEL && !chop_r |-> run_r == pl + 8'h02)
    else $error("selected chop length wrong");
  a_eight_beat: assert property ($fell(dqs) && bm != BM_CHOP && (bm != BM_SEL || chop_r)
    |-> run_r == pl + 8'h04) else $error("eight-beat length wrong");
  a_chop_ignored: assert property ($fell(dqs) && bm != BM_SEL && chop_r |-> run_r == pl + nb)
    else $error("chop bit not ignored");
  a_data_start: assert property ($rose(dqs) |-> age_r == wlat - pl - 8'h01)
    else $error("strobe start off latency");
  a_pre_gap: assert property (cmd == SDWB_PRE |-> age_r >= wlat + nb)
    else $error("precharge too early");
  a_turn_gap: assert property (cmd == SDWB_RD |-> age_r >= wlat + nb)
    else $error("read too early");
  a_clat_pre2: assert property (cmd == SDWB_WR && mode_r[PRE2_BIT] |->
    mode_r[CLAT_LSB+:5] != CLAT_FORBID) else $error("forbidden latency used");
  a_no_six: assert property (cmd == SDWB_WR && mode_r[PRE2_BIT] |-> age_r != 8'h05)
    else $error("write spacing of six");
  a_reinit_seq: assert property ($rose(dev_rst) |-> s_rst_hold ##1 s_reload)
    else $error("reinit sequence wrong");
endmodule // sdwb_props
`default_nettype wire

// >>> tb/sdwb_test.sv
// Self-checking bench for the write-burst controller and device pair
`timescale 1ns/100ps
`default_nettype none
module sdwb_test import sdwb_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        wvld = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  ra = 4'h0;
  logic [31:0] prd, r;
  logic [15:0] rd, bdat, last_b;
  logic        prdy, perr, e, wrdy, dchop, bvld, derr;
  logic [31:0] q [$];
  int          n_mismatch = 0, samples_checked = 0;
  int          cyc = 0, t_wr, t_pre, t_rd, t0, n_err = 0, n_bv = 0;
  logic [13:0] tm [7] = '{14'h0024, 14'h0025, 14'h0025, 14'h0026, 14'h0824, 14'h3024, 14'h3824};
  logic        tc [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int          tr [7] = '{12, 12, 12, 12, 13, 14, 14};
  int          tt [7] = '{2, 2, 2, 2, 2, 3, 3};
  sdwb_if lnk ();
  sdwb_if lnk2 ();
  sdwb_ctl sdwb_ctl_inst (.core_clk_i(clk), .sys_rst_i(rst), .paddr_i(pa), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .wdata_i(wdat), .wvalid_i(wvld), .wready_o(wrdy), .link(lnk.ctl));
  sdwb_dev sdwb_dev_inst (.core_clk_i(clk), .sys_rst_i(rst), .link(lnk.dev), .rd_addr_i(ra),
    .rd_data_o(rd), .beat_vld_o(), .beat_data_o(), .chop_o(dchop), .wr_err_o());
  // Second device faces the bench, which breaks the strobe timing on purpose
  sdwb_dev sdwb_dev_inst2 (.core_clk_i(clk), .sys_rst_i(rst), .link(lnk2.dev), .rd_addr_i(4'h0),
    .rd_data_o(), .beat_vld_o(bvld), .beat_data_o(bdat), .chop_o(), .wr_err_o(derr));
  sdwb_props sdwb_props_inst (.core_clk_i(clk), .sys_rst_i(rst), .cmd(lnk.cmd), .chop(lnk.chop),
    .mode(lnk.mode), .dqs(lnk.dqs), .dev_rst(lnk.dev_rst));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (lnk.cmd === SDWB_WR) t_wr = cyc;
    if (lnk.cmd === SDWB_PRE) t_pre = cyc;
    if (lnk.cmd === SDWB_RD) t_rd = cyc;
    if (derr === 1'b1) n_err++;
    if (bvld === 1'b1) begin
      n_bv++;
      last_b = bdat;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pa <= a;
    pwr <= w;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic push(input logic [31:0] d);
    @(posedge clk);
    wvld <= 1'b1;
    wdat <= d;
    do @(posedge clk); while (wrdy !== 1'b1);
    wvld <= 1'b0;
    q.push_back(d);
  endtask
  task automatic burst(input logic [13:0] m, input logic c, input int rec, input int trn);
    int n;
    int wlat;
    logic [31:0] w;
    wlat = m[9:7] + m[6:2];
    n = (m[1:0] == 2'h2 || (m[1:0] == 2'h1 && !c)) ? 2 : 4;
    while (q.size() < n / 2) push(32'h5A000000 + cyc);
    apb(1'b1, A_MODE, {18'h0, m});
    apb(1'b1, A_CTRL, {24'h0, 8'h59 | {6'h0, c, 1'b0}});
    do apb(1'b0, A_STAT, 32'h0); while (r[S_DONE] !== 1'b1);
    apb(1'b1, A_STAT, 32'h4);
    chk(t_pre - t_wr, wlat + n + rec);
    chk(t_rd - t_wr, wlat + n + trn);
    chk({31'h0, dchop}, n == 2);
    for (int i = 0; i < n; i++) begin
      if (i % 2 == 0) w = q.pop_front();
      @(posedge clk);
      ra <= {2'h2, i[1:0]};
      repeat (2) @(posedge clk);
      chk({16'h0, rd}, i % 2 ? {16'h0, w[31:16]} : {16'h0, w[15:0]});
    end
  endtask
  task automatic wr2(input logic s);
    @(posedge clk);
    lnk2.cmd <= SDWB_WR;
    @(posedge clk);
    lnk2.cmd <= SDWB_NOP;
    repeat (7) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      lnk2.dqs <= s;
      lnk2.dq <= 16'h3C00 + i[15:0];
      @(posedge clk);
    end
    lnk2.dqs <= 1'b0;
    lnk2.dq <= ~lnk2.dq;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    lnk2.cmd = SDWB_NOP;
    lnk2.bank = 2'h0;
    lnk2.chop = 1'b0;
    lnk2.mode = MODE_RST;
    lnk2.dq = 16'h0;
    lnk2.dmi_n = DMI_IDLE;
    lnk2.dqs = 1'b0;
    lnk2.dev_rst = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, A_TIM0, 32'h0);
    chk(r, TIM0_RST);
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int k = 0; k < 4; k++) push(32'hC0DE0000 + k);
    @(posedge clk);
    chk({31'h0, wrdy}, 32'h0);
    for (int k = 0; k < 7; k++) burst(tm[k], tc[k], tr[k], tt[k]);
    t0 = t_wr;
    apb(1'b1, A_MODE, 32'h0424);
    apb(1'b1, A_CTRL, 32'h11);
    do apb(1'b0, A_STAT, 32'h0); while (r[S_CFGERR] !== 1'b1);
    chk(t_wr, t0);
    apb(1'b1, A_STAT, 32'h2);
    burst(14'h0428, 1'b0, 12, 2);
    apb(1'b1, A_CTRL, 32'h20);
    burst(14'h0025, 1'b1, 12, 2);
    wr2(1'b0);
    chk(n_err, 1);
    wr2(1'b1);
    chk(n_err, 1);
    chk(n_bv, 4);
    chk({16'h0, last_b}, 32'h3C04);
    give_verdict;
  end
endmodule // sdwb_test
`default_nettype wire
